// ==== pma_breaker_router.sv ====
// Routes gated trip commands to one breaker by an assignment mask.
`timescale 1ns/1ns
module pma_breaker_router
	import pma_pkg::*;
(
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_b,
	input  wire logic [PMA_NUM_STAGES-1:0] i_cmd,
	input  wire logic [PMA_NUM_STAGES-1:0] i_assign,
	output logic                           o_breaker_open_command
);

	typedef struct packed {
		logic open;
	} pma_rtr_t;

	pma_rtr_t s_q;
	pma_rtr_t s_d;

	always_comb begin
		s_d = s_q;
		// RULE_11: only assigned commands operate
		s_d.open = |(i_cmd & i_assign);
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_breaker_open_command = s_q.open;

	a_route_assigned: assert property ( // RULE_11
		@(posedge i_clk) disable iff (!i_rst_b)
		(~|(i_cmd & i_assign)) |=> !o_breaker_open_command)
		else $error("Unassigned command opened breaker.");

endmodule // pma_breaker_router

// ==== pma_field_model.sv ====
// Field model: protection fault sources and two circuit breakers.
`timescale 1ns/1ns
module pma_field_model
	import pma_pkg::*;
(
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_b,
	input  wire logic [PMA_NUM_STAGES-1:0] i_fault_set,
	input  wire logic [PMA_NUM_PH-1:0]     i_phase_set,
	input  wire logic [PMA_NUM_BRKS-1:0]   i_open_cmd,
	input  wire logic                      i_close,
	output logic [PMA_NUM_STAGES-1:0]      o_fault,
	output logic [PMA_NUM_STAGES-1:0]      o_ph_a,
	output logic [PMA_NUM_STAGES-1:0]      o_ph_b,
	output logic [PMA_NUM_STAGES-1:0]      o_ph_c,
	output logic [PMA_NUM_BRKS-1:0]        o_open_q
);
	// Healthy stages show every phase flag set, so a design that trusts the
	// phase flags without the fault level shows spurious phase signals.
	assign o_fault = i_fault_set;
	assign o_ph_a  = ~i_fault_set | {PMA_NUM_STAGES{i_phase_set[0]}};
	assign o_ph_b  = ~i_fault_set | {PMA_NUM_STAGES{i_phase_set[1]}};
	assign o_ph_c  = ~i_fault_set | {PMA_NUM_STAGES{i_phase_set[2]}};

	// A breaker stays open once commanded until i_close, so even a one-cycle command shows.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_open_q <= '0;
		end else if (i_close) begin
			o_open_q <= '0;
		end else begin
			o_open_q <= o_open_q | i_open_cmd;
		end
	end
endmodule // pma_field_model

// ==== pma_master.sv ====
// Protection master frame: blocking, collective signals, command gating.
//
// Overview of operation
// RULE_01: A disabled or blocked master stops all alarms, trips and commands.
// RULE_02: With permit, either external block input blocks whole protection.
// RULE_03: Permanent inhibit stops trip commands; alarms and trips remain.
// RULE_04: With permit, the inhibit input stops all trip commands.
// RULE_05: A stage raises its alarm as soon as it sees its fault.
// RULE_06: General alarm is OR of all reporting stage alarms.
// RULE_07: A stage trips only if fault persists past its own delay.
// RULE_08: General trip is OR of all reporting stage trips.
// RULE_09: A stage issues its command on trip only when commands unblocked.
// RULE_10: Supervision-only stages have no command output or command blocking.
// RULE_11: Each breaker router is operated only by commands assigned to it.
// RULE_12: Each phase alarm output ORs all stage alarms for that phase.
// RULE_13: Each phase trip output ORs all stage trips for that phase.
// RULE_14: Only single-phase, non-supervision stages feed phase outputs.
// RULE_15: Ground alarm ORs the alarms of ground current and voltage stages.
// RULE_16: Supervision-only stages never report to master nor open breakers.
// RULE_17: Phase-selective stage trips raise the matching phase trip outputs.
// RULE_18: All collective and gating outputs are registered and reset clear.
`timescale 1ns/1ns
module pma_master
	import pma_pkg::*;
(
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_b,
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [11:0]               i_paddr,
	input  wire logic [31:0]               i_pwdata,
	output logic [31:0]                    o_prdata,
	output logic                           o_pready,
	output logic                           o_pslverr,
	input  wire logic                      i_ext_block_in_a,
	input  wire logic                      i_ext_block_in_b,
	input  wire logic                      i_ext_command_inhibit_in,
	input  wire logic [PMA_NUM_STAGES-1:0] i_stage_fault,
	input  wire logic [PMA_NUM_STAGES-1:0] i_fault_ph_a,
	input  wire logic [PMA_NUM_STAGES-1:0] i_fault_ph_b,
	input  wire logic [PMA_NUM_STAGES-1:0] i_fault_ph_c,
	output logic                           o_general_alarm,
	output logic                           o_general_trip,
	output logic                           o_phase_a_alarm,
	output logic                           o_phase_b_alarm,
	output logic                           o_phase_c_alarm,
	output logic                           o_phase_a_trip,
	output logic                           o_phase_b_trip,
	output logic                           o_phase_c_trip,
	output logic                           o_ground_alarm,
	output logic                           o_protection_blocked,
	output logic                           o_command_blocked,
	output logic [PMA_NUM_STAGES-1:0]      o_stage_command,
	output logic [PMA_NUM_BRKS-1:0]        o_breaker_open_command,
	output logic                           o_irq
);

	typedef struct packed {
		logic [31:0]               ctrl;
		logic [PMA_NUM_STAGES-1:0] supv;
		logic [PMA_NUM_STAGES-1:0] oneph;
		logic [PMA_NUM_STAGES-1:0] gndsel;
		logic [PMA_NUM_STAGES-1:0] route0;
		logic [PMA_NUM_STAGES-1:0] route1;
		logic [PMA_ST_W-1:0]       irq_st;
		logic [PMA_ST_W-1:0]       irq_msk;
		logic [PMA_ST_W-1:0]       ev_prev;
		logic [2:0]                blk_a_s;
		logic [2:0]                blk_b_s;
		logic [2:0]                inh_s;
		logic                      blocked;
		logic                      cmd_blk;
		logic                      g_alarm;
		logic                      g_trip;
		logic [2:0]                ph_alarm;
		logic [2:0]                ph_trip;
		logic                      gnd_alarm;
		logic [PMA_NUM_STAGES-1:0] cmd;
		logic [31:0]               rdata;
	} pma_state_t;

	pma_state_t s_q;
	pma_state_t s_d;

	logic [PMA_DLY_W-1:0]      delay_q [PMA_NUM_STAGES];
	logic [PMA_NUM_STAGES-1:0] st_alarm;
	logic [PMA_NUM_STAGES-1:0] st_trip;
	logic [PMA_NUM_STAGES-1:0] st_active;
	logic [PMA_NUM_STAGES-1:0] ph_a_trip;
	logic [PMA_NUM_STAGES-1:0] ph_b_trip;
	logic [PMA_NUM_STAGES-1:0] ph_c_trip;
	logic [PMA_NUM_STAGES-1:0] ph_a_alm;
	logic [PMA_NUM_STAGES-1:0] ph_b_alm;
	logic [PMA_NUM_STAGES-1:0] ph_c_alm;
	logic [PMA_NUM_STAGES-1:0] report;
	logic [PMA_NUM_STAGES-1:0] phase_ok;
	logic                      blk_now;
	logic                      inh_now;
	logic                      wr_en;
	logic                      rd_en;
	logic                      dly_sel;
	logic [2:0]                dly_idx;
	logic [PMA_ST_W-1:0]       events;

	assign wr_en   = i_psel && i_penable && i_pwrite;
	assign rd_en   = i_psel && !i_penable && !i_pwrite;
	assign dly_sel = (i_paddr[11:5] == PMA_OFF_DELAY0[11:5]);
	assign dly_idx = i_paddr[4:2];

	// RULE_02: external blocking with permit
	assign blk_now = s_q.ctrl[PMA_CTRL_EXT_PERMIT]
		&& (s_q.blk_a_s[1] || s_q.blk_b_s[1]);
	// RULE_04: temporary command inhibit with permit
	assign inh_now = s_q.ctrl[PMA_CTRL_CMD_PERMIT] && s_q.inh_s[1];

	// RULE_16: supervision stages do not report
	assign report   = ~s_q.supv;
	// RULE_14: phase contribution needs 1p ability
	assign phase_ok = s_q.oneph & ~s_q.supv;

	genvar g;
	generate
		for (g = 0; g < PMA_NUM_STAGES; g++) begin : g_stage
			// RULE_01: disabled master halts every stage
			assign st_active[g] = s_q.ctrl[PMA_CTRL_ENABLE] && !s_q.blocked;
			pma_stage_timer u_tmr (
				.i_clk   (i_clk),
				.i_rst_b (i_rst_b),
				.i_fault (i_stage_fault[g]),
				.i_active(st_active[g]),
				.i_delay (delay_q[g]),
				.o_alarm (st_alarm[g]),
				.o_trip  (st_trip[g])
			);
			// RULE_17: phase trips of phase-selective stages
			assign ph_a_trip[g] = st_trip[g] && i_fault_ph_a[g];
			assign ph_b_trip[g] = st_trip[g] && i_fault_ph_b[g];
			assign ph_c_trip[g] = st_trip[g] && i_fault_ph_c[g];
			assign ph_a_alm[g]  = st_alarm[g] && i_fault_ph_a[g];
			assign ph_b_alm[g]  = st_alarm[g] && i_fault_ph_b[g];
			assign ph_c_alm[g]  = st_alarm[g] && i_fault_ph_c[g];

			always_ff @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					delay_q[g] <= PMA_RST_DELAY;
				end else if (wr_en && dly_sel
					&& dly_idx == 3'(g)) begin
					delay_q[g] <= i_pwdata[PMA_DLY_W-1:0];
				end
			end
		end
	endgenerate

	assign events = {s_q.gnd_alarm, s_q.blocked, |s_q.cmd,
		s_q.g_trip, s_q.g_alarm};

	always_comb begin
		s_d = s_q;
		// External levels pass two flip-flops before use.
		s_d.blk_a_s = {s_q.blk_a_s[1:0], i_ext_block_in_a};
		s_d.blk_b_s = {s_q.blk_b_s[1:0], i_ext_block_in_b};
		s_d.inh_s   = {s_q.inh_s[1:0], i_ext_command_inhibit_in};
		s_d.blocked = blk_now;
		// RULE_03: permanent command inhibit
		s_d.cmd_blk = s_q.ctrl[PMA_CTRL_PERM_INH] || inh_now;

		// RULE_18: registered collective outputs
		if (!s_q.ctrl[PMA_CTRL_ENABLE] || s_q.blocked) begin
			s_d.g_alarm   = 1'b0;
			s_d.g_trip    = 1'b0;
			s_d.ph_alarm  = 3'h0;
			s_d.ph_trip   = 3'h0;
			s_d.gnd_alarm = 1'b0;
			s_d.cmd       = '0;
		end else begin
			// RULE_06: general alarm OR
			s_d.g_alarm = |(st_alarm & report);
			// RULE_08: general trip OR
			s_d.g_trip  = |(st_trip & report);
			// RULE_12: per-phase alarm OR
			s_d.ph_alarm = {|(ph_c_alm & phase_ok), |(ph_b_alm & phase_ok),
				|(ph_a_alm & phase_ok)};
			// RULE_13: per-phase trip OR
			s_d.ph_trip = {|(ph_c_trip & phase_ok), |(ph_b_trip & phase_ok),
				|(ph_a_trip & phase_ok)};
			// RULE_15: ground collective alarm
			s_d.gnd_alarm = |(st_alarm & report & s_q.gndsel);
			// RULE_09: commands only while unblocked
			// RULE_10: supervision stages get no command
			if (s_d.cmd_blk) begin
				s_d.cmd = '0;
			end else begin
				s_d.cmd = st_trip & report;
			end
		end

		// Rising edges of status events latch; set wins over clear.
		s_d.ev_prev = events;
		if (wr_en && i_paddr == PMA_OFF_IRQ_ST) begin
			s_d.irq_st = s_q.irq_st & ~i_pwdata[PMA_ST_W-1:0];
		end
		s_d.irq_st = s_d.irq_st | (events & ~s_q.ev_prev);

		if (wr_en) begin
			case (i_paddr)
				PMA_OFF_CTRL:    s_d.ctrl    = {28'h0, i_pwdata[3:0]};
				PMA_OFF_IRQ_MSK: s_d.irq_msk = i_pwdata[PMA_ST_W-1:0];
				PMA_OFF_SUPV:    s_d.supv    = i_pwdata[PMA_NUM_STAGES-1:0];
				PMA_OFF_ONEPH:   s_d.oneph   = i_pwdata[PMA_NUM_STAGES-1:0];
				PMA_OFF_GNDSEL:  s_d.gndsel  = i_pwdata[PMA_NUM_STAGES-1:0];
				PMA_OFF_ROUTE0:  s_d.route0  = i_pwdata[PMA_NUM_STAGES-1:0];
				PMA_OFF_ROUTE1:  s_d.route1  = i_pwdata[PMA_NUM_STAGES-1:0];
				default: ;
			endcase
		end

		// Read data is captured in setup so the access phase needs no wait.
		if (rd_en) begin
			case (i_paddr)
				PMA_OFF_CTRL:    s_d.rdata = s_q.ctrl;
				PMA_OFF_STATUS:  s_d.rdata = {27'h0, events};
				PMA_OFF_IRQ_ST:  s_d.rdata = {27'h0, s_q.irq_st};
				PMA_OFF_IRQ_MSK: s_d.rdata = {27'h0, s_q.irq_msk};
				PMA_OFF_SUPV:    s_d.rdata = {24'h0, s_q.supv};
				PMA_OFF_ONEPH:   s_d.rdata = {24'h0, s_q.oneph};
				PMA_OFF_GNDSEL:  s_d.rdata = {24'h0, s_q.gndsel};
				PMA_OFF_ROUTE0:  s_d.rdata = {24'h0, s_q.route0};
				PMA_OFF_ROUTE1:  s_d.rdata = {24'h0, s_q.route1};
				default: begin
					if (dly_sel) begin
						s_d.rdata = {16'h0, delay_q[dly_idx]};
					end else begin
						s_d.rdata = PMA_RST_ZERO;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	pma_breaker_router u_rtr0 (
		.i_clk                 (i_clk),
		.i_rst_b               (i_rst_b),
		.i_cmd                 (s_q.cmd),
		.i_assign              (s_q.route0),
		.o_breaker_open_command(o_breaker_open_command[0])
	);

	pma_breaker_router u_rtr1 (
		.i_clk                 (i_clk),
		.i_rst_b               (i_rst_b),
		.i_cmd                 (s_q.cmd),
		.i_assign              (s_q.route1),
		.o_breaker_open_command(o_breaker_open_command[1])
	);

	assign o_prdata  = s_q.rdata;
	assign o_pready  = 1'b1;
	assign o_pslverr = 1'b0;
	assign o_general_alarm      = s_q.g_alarm;
	assign o_general_trip       = s_q.g_trip;
	assign o_phase_a_alarm      = s_q.ph_alarm[0];
	assign o_phase_b_alarm      = s_q.ph_alarm[1];
	assign o_phase_c_alarm      = s_q.ph_alarm[2];
	assign o_phase_a_trip       = s_q.ph_trip[0];
	assign o_phase_b_trip       = s_q.ph_trip[1];
	assign o_phase_c_trip       = s_q.ph_trip[2];
	assign o_ground_alarm       = s_q.gnd_alarm;
	assign o_protection_blocked = s_q.blocked;
	assign o_command_blocked    = s_q.cmd_blk;
	assign o_stage_command      = s_q.cmd;
	assign o_irq                = |(s_q.irq_st & s_q.irq_msk);

	a_disabled_quiet: assert property ( // RULE_01
		@(posedge i_clk) disable iff (!i_rst_b)
		$past(!s_q.ctrl[PMA_CTRL_ENABLE] || s_q.blocked)
		|-> !o_general_trip && o_stage_command == '0)
		else $error("Output while protection off.");

	a_ext_block: assert property ( // RULE_02
		@(posedge i_clk) disable iff (!i_rst_b)
		(s_q.ctrl[PMA_CTRL_EXT_PERMIT] && s_q.blk_a_s[1]) |=>
		o_protection_blocked)
		else $error("Block input ignored.");

	a_ext_block_b: assert property ( // RULE_02
		@(posedge i_clk) disable iff (!i_rst_b)
		(s_q.ctrl[PMA_CTRL_EXT_PERMIT] && s_q.blk_b_s[1]) |=>
		o_protection_blocked)
		else $error("Second block input ignored.");

	a_perm_inhibit: assert property ( // RULE_03
		@(posedge i_clk) disable iff (!i_rst_b)
		s_q.ctrl[PMA_CTRL_PERM_INH] |=> o_stage_command == '0)
		else $error("Command despite permanent inhibit.");

	a_temp_inhibit: assert property ( // RULE_04
		@(posedge i_clk) disable iff (!i_rst_b)
		inh_now |=> o_command_blocked && o_stage_command == '0)
		else $error("Command despite inhibit input.");

	a_general_alarm: assert property ( // RULE_06
		@(posedge i_clk) disable iff (!i_rst_b)
		(s_q.ctrl[PMA_CTRL_ENABLE] && !s_q.blocked) |=>
		o_general_alarm == $past(|(st_alarm & ~s_q.supv)))
		else $error("General alarm mismatch.");

	a_general_trip: assert property ( // RULE_08
		@(posedge i_clk) disable iff (!i_rst_b)
		o_general_trip |-> $past(|(st_trip & ~s_q.supv)))
		else $error("General trip without stage trip.");

	a_cmd_gated: assert property ( // RULE_09
		@(posedge i_clk) disable iff (!i_rst_b)
		(o_stage_command != '0) |-> o_general_trip && !o_command_blocked)
		else $error("Command without trip or while blocked.");

	a_supv_no_cmd: assert property ( // RULE_10
		@(posedge i_clk) disable iff (!i_rst_b)
		(o_stage_command & $past(s_q.supv)) == '0)
		else $error("Supervision stage commanded.");

	a_phase_alarm: assert property ( // RULE_12
		@(posedge i_clk) disable iff (!i_rst_b)
		o_phase_b_alarm |-> $past(|(st_alarm & i_fault_ph_b & phase_ok)))
		else $error("Phase alarm without source.");

	a_phase_trip: assert property ( // RULE_13
		@(posedge i_clk) disable iff (!i_rst_b)
		o_phase_a_trip |-> $past(|(ph_a_trip & phase_ok)))
		else $error("Phase trip without source.");

	a_phase_only: assert property ( // RULE_14
		@(posedge i_clk) disable iff (!i_rst_b)
		(o_phase_a_alarm || o_phase_c_alarm)
		|-> $past(|(st_alarm & s_q.oneph & ~s_q.supv)))
		else $error("Phase alarm from excluded stage.");

	a_ground_alarm: assert property ( // RULE_15
		@(posedge i_clk) disable iff (!i_rst_b)
		o_ground_alarm |-> o_general_alarm
		&& $past(|(st_alarm & s_q.gndsel & ~s_q.supv)))
		else $error("Ground alarm without ground stage.");

	a_phase_in_trip: assert property ( // RULE_17
		@(posedge i_clk) disable iff (!i_rst_b)
		(o_phase_b_trip || o_phase_c_trip) |-> o_general_trip)
		else $error("Phase trip without general trip.");

endmodule // pma_master

// ==== pma_pkg.sv ====
// Shared constants for the protection master aggregator.
package pma_pkg;

	localparam int PMA_NUM_STAGES = 8;
	localparam int PMA_NUM_BRKS   = 2;
	localparam int PMA_NUM_PH     = 3;
	localparam int PMA_DLY_W      = 16;

	// Register byte offsets.
	localparam logic [11:0] PMA_OFF_CTRL    = 12'h000;
	localparam logic [11:0] PMA_OFF_STATUS  = 12'h004;
	localparam logic [11:0] PMA_OFF_IRQ_ST  = 12'h008;
	localparam logic [11:0] PMA_OFF_IRQ_MSK = 12'h00C;
	localparam logic [11:0] PMA_OFF_SUPV    = 12'h010;
	localparam logic [11:0] PMA_OFF_ONEPH   = 12'h014;
	localparam logic [11:0] PMA_OFF_GNDSEL  = 12'h018;
	localparam logic [11:0] PMA_OFF_ROUTE0  = 12'h01C;
	localparam logic [11:0] PMA_OFF_ROUTE1  = 12'h020;
	localparam logic [11:0] PMA_OFF_DELAY0  = 12'h040;

	// Control register fields.
	localparam int PMA_CTRL_ENABLE      = 0;
	localparam int PMA_CTRL_EXT_PERMIT  = 1;
	localparam int PMA_CTRL_PERM_INH    = 2;
	localparam int PMA_CTRL_CMD_PERMIT  = 3;

	// Status / interrupt fields.
	localparam int PMA_ST_ALARM   = 0;
	localparam int PMA_ST_TRIP    = 1;
	localparam int PMA_ST_CMD     = 2;
	localparam int PMA_ST_BLOCKED = 3;
	localparam int PMA_ST_GND     = 4;
	localparam int PMA_ST_W       = 5;

	// Values after reset.
	localparam logic [31:0] PMA_RST_CTRL  = 32'h0000_0000;
	localparam logic [31:0] PMA_RST_ZERO  = 32'h0000_0000;
	localparam logic [PMA_DLY_W-1:0] PMA_RST_DELAY = 16'h000A;

endpackage : pma_pkg

// ==== pma_stage_timer.sv ====
// One protection stage: alarm on fault, trip after its own delay.
`timescale 1ns/1ns
module pma_stage_timer
	import pma_pkg::*;
(
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_b,
	input  wire logic                 i_fault,
	input  wire logic                 i_active,
	input  wire logic [PMA_DLY_W-1:0] i_delay,
	output logic                      o_alarm,
	output logic                      o_trip
);

	typedef struct packed {
		logic [PMA_DLY_W-1:0] cnt;
		logic                 alarm;
		logic                 trip;
	} pma_tmr_t;

	pma_tmr_t s_q;
	pma_tmr_t s_d;

	always_comb begin
		s_d = s_q;
		if (!i_active || !i_fault) begin
			s_d.cnt   = '0;
			s_d.alarm = 1'b0;
			s_d.trip  = 1'b0;
		end else begin
			// RULE_05: alarm follows fault
			s_d.alarm = 1'b1;
			// RULE_07: trip after delay expires
			if (s_q.cnt >= i_delay) begin
				s_d.trip = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_alarm = s_q.alarm;
	assign o_trip  = s_q.trip;

	a_trip_needs_alarm: assert property ( // RULE_07
		@(posedge i_clk) disable iff (!i_rst_b)
		o_trip |-> o_alarm) else $error("Trip without alarm.");

	a_alarm_follows: assert property ( // RULE_05
		@(posedge i_clk) disable iff (!i_rst_b)
		(i_fault && i_active) |=> o_alarm)
		else $error("Alarm missed a fault.");

endmodule // pma_stage_timer

// ==== protection_master_aggregator_tb.sv ====
// Self-checking bench for the protection master frame.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
	mismatches++; $display("Error %s expected %0h seen %0h", nm, ex, got); \
	end end
module protection_master_aggregator_tb
	import pma_pkg::*;
;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        blk_a, blk_b, inh_in, close, irq;
	logic [7:0]  fault_set, s_fault, ph_a, ph_b, ph_c, stage_cmd;
	logic [2:0]  phase_set, ph_alarm, ph_trip;
	logic [1:0]  brk_cmd, brk_open;
	logic        gen_alarm, gen_trip, gnd, prot_blk, cmd_blk;
	logic [20:0] obs;
	int          mismatches, compares;

	assign obs = {gen_alarm, gen_trip, ph_alarm, ph_trip, gnd, prot_blk,
		cmd_blk, stage_cmd, brk_cmd};

	pma_master uut (.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_ext_block_in_a(blk_a),
		.i_ext_block_in_b(blk_b), .i_ext_command_inhibit_in(inh_in),
		.i_stage_fault(s_fault), .i_fault_ph_a(ph_a), .i_fault_ph_b(ph_b),
		.i_fault_ph_c(ph_c), .o_general_alarm(gen_alarm),
		.o_general_trip(gen_trip), .o_phase_a_alarm(ph_alarm[0]),
		.o_phase_b_alarm(ph_alarm[1]), .o_phase_c_alarm(ph_alarm[2]),
		.o_phase_a_trip(ph_trip[0]), .o_phase_b_trip(ph_trip[1]),
		.o_phase_c_trip(ph_trip[2]), .o_ground_alarm(gnd),
		.o_protection_blocked(prot_blk), .o_command_blocked(cmd_blk),
		.o_stage_command(stage_cmd), .o_breaker_open_command(brk_cmd),
		.o_irq(irq));

	pma_field_model field (.i_clk(clk), .i_rst_b(rst_b),
		.i_fault_set(fault_set), .i_phase_set(phase_set),
		.i_open_cmd(brk_cmd), .i_close(close), .o_fault(s_fault),
		.o_ph_a(ph_a), .o_ph_b(ph_b), .o_ph_c(ph_c), .o_open_q(brk_open));

	always #5 clk = ~clk;

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [31:0] ex);
		apb(1'h0, a, 32'h0);
		`CHK(nm, ex, rd)
	endtask

	task automatic stim(input logic [7:0] f, input logic [2:0] p);
		@(posedge clk);
		fault_set <= f;
		phase_set <= p;
	endtask

	// Checks look just after the edge so that its updates have landed.
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge clk);
		mismatches++;
		wrap_up();
	end

	initial begin
		clk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = '0; pwdata = '0; blk_a = 0; blk_b = 0; inh_in = 0;
		fault_set = '0; phase_set = '0; close = 0;
		mismatches = 0; compares = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		rdc("ctrl", PMA_OFF_CTRL, PMA_RST_CTRL);
		rdc("delay0", PMA_OFF_DELAY0, {16'h0, PMA_RST_DELAY});
		rdc("unmapped", 12'h0FC, PMA_RST_ZERO);
		`CHK("slverr", 1'h0, pslverr)
		stim(8'h01, 3'h1);
		settle(12);
		`CHK("disabled", 21'h0, obs)
		stim(8'h00, 3'h0);
		$display("Test reset and disable done");
		// Stage 1 gets a long delay so its trip timing is told apart.
		for (int i = 0; i < PMA_NUM_STAGES; i++) begin
			apb(1'h1, PMA_OFF_DELAY0 + 12'(4 * i), (i == 1) ? 32'h14 : 32'h3);
		end
		apb(1'h1, PMA_OFF_SUPV, 32'h80);
		apb(1'h1, PMA_OFF_ONEPH, 32'h83);
		apb(1'h1, PMA_OFF_GNDSEL, 32'h84);
		apb(1'h1, PMA_OFF_ROUTE0, 32'h81);
		apb(1'h1, PMA_OFF_ROUTE1, 32'h02);
		apb(1'h1, PMA_OFF_CTRL, 32'h1);
		stim(8'h01, 3'h1);
		settle(2);
		`CHK("alarm", {2'h2, 3'h1, 3'h0, 3'h0, 8'h0, 2'h0}, obs)
		settle(10);
		`CHK("trip", {2'h3, 3'h1, 3'h1, 3'h0, 8'h1, 2'h1}, obs)
		`CHK("open", 2'h1, brk_open)
		rdc("status", PMA_OFF_STATUS, 32'h07);
		stim(8'h00, 3'h0);
		settle(4);
		`CHK("clear", 21'h0, obs)
		$display("Test single stage done");
		for (int p = 0; p < 3; p++) begin
			stim(8'h02, 3'(1 << p));
			settle(12);
			`CHK("ph early", {2'h2, 3'(1 << p), 3'h0, 3'h0, 8'h0, 2'h0}, obs)
			settle(16);
			`CHK("ph trip", {2'h3, 3'(1 << p), 3'(1 << p), 3'h0, 8'h2, 2'h2},
				obs)
			stim(8'h00, 3'h0);
			settle(4);
		end
		$display("Test phases done");
		@(posedge clk);
		close <= 1'h1;
		@(posedge clk);
		close <= 1'h0;
		stim(8'h84, 3'h7);
		settle(12);
		`CHK("gnd supv", {2'h3, 3'h0, 3'h0, 3'h4, 8'h4, 2'h0}, obs)
		stim(8'h80, 3'h7);
		settle(12);
		`CHK("supv", 21'h0, obs)
		`CHK("no open", 2'h0, brk_open)
		$display("Test ground and supervision done");
		apb(1'h1, PMA_OFF_CTRL, 32'h5);
		stim(8'h01, 3'h1);
		settle(12);
		`CHK("perm", {2'h3, 3'h1, 3'h1, 3'h1, 8'h0, 2'h0}, obs)
		apb(1'h1, PMA_OFF_CTRL, 32'h9);
		settle(6);
		`CHK("unblk", {2'h3, 3'h1, 3'h1, 3'h0, 8'h1, 2'h1}, obs)
		@(posedge clk);
		inh_in <= 1'h1;
		settle(6);
		`CHK("temp", {2'h3, 3'h1, 3'h1, 3'h1, 8'h0, 2'h0}, obs)
		apb(1'h1, PMA_OFF_CTRL, 32'h1);
		settle(6);
		`CHK("no permit", {2'h3, 3'h1, 3'h1, 3'h0, 8'h1, 2'h1}, obs)
		$display("Test command blocking done");
		apb(1'h1, PMA_OFF_CTRL, 32'h3);
		@(posedge clk);
		inh_in <= 1'h0;
		blk_a <= 1'h1;
		settle(6);
		`CHK("block a", {2'h0, 3'h0, 3'h0, 3'h2, 8'h0, 2'h0}, obs)
		@(posedge clk);
		blk_a <= 1'h0;
		blk_b <= 1'h1;
		settle(6);
		`CHK("block b", {2'h0, 3'h0, 3'h0, 3'h2, 8'h0, 2'h0}, obs)
		apb(1'h1, PMA_OFF_CTRL, 32'h1);
		settle(12);
		`CHK("no ext", {2'h3, 3'h1, 3'h1, 3'h0, 8'h1, 2'h1}, obs)
		@(posedge clk);
		blk_b <= 1'h0;
		stim(8'h00, 3'h0);
		settle(4);
		$display("Test external blocking done");
		apb(1'h1, PMA_OFF_IRQ_ST, 32'h1F);
		apb(1'h1, PMA_OFF_IRQ_MSK, 32'h01);
		settle(2);
		`CHK("irq idle", 1'h0, irq)
		stim(8'h01, 3'h1);
		settle(4);
		`CHK("irq set", 1'h1, irq)
		settle(8);
		rdc("irq st", PMA_OFF_IRQ_ST, 32'h07);
		apb(1'h1, PMA_OFF_IRQ_MSK, 32'h00);
		settle(2);
		`CHK("irq mask", 1'h0, irq)
		stim(8'h00, 3'h0);
		settle(4);
		apb(1'h1, PMA_OFF_IRQ_ST, 32'h07);
		rdc("irq clr", PMA_OFF_IRQ_ST, 32'h0);
		apb(1'h1, PMA_OFF_IRQ_MSK, 32'h01);
		settle(2);
		`CHK("irq off", 1'h0, irq)
		$display("Test interrupt done");
		stim(8'h01, 3'h1);
		settle(12);
		@(posedge clk);
		rst_b <= 1'h0;
		#1;
		`CHK("rst outs", 22'h0, {irq, obs})
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		rdc("rst delay", PMA_OFF_DELAY0, {16'h0, PMA_RST_DELAY});
		settle(4);
		`CHK("rst off", 21'h0, obs)
		$display("Test reset in run done");
		wrap_up();
	end
endmodule // protection_master_aggregator_tb
